// file: core/ttc_defines.svh
// Purpose: constants of the three timer/counter unit
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH
// register indices
`define TTC_IDX_TCF   8'h88
`define TTC_IDX_TMS   8'h89
`define TTC_IDX_TL0   8'h8A
`define TTC_IDX_TL1   8'h8B
`define TTC_IDX_TH0   8'h8C
`define TTC_IDX_TH1   8'h8D
`define TTC_IDX_T2C   8'hC8
`define TTC_IDX_RCL   8'hCA
`define TTC_IDX_RCH   8'hCB
`define TTC_IDX_TL2   8'hCC
`define TTC_IDX_TH2   8'hCD
// reset value of every register
`define TTC_RST8      8'h00
// timer_control_flags fields
`define TTC_TF1       7
`define TTC_TR1       6
`define TTC_TF0       5
`define TTC_TR0       4
// timer_mode_select fields
`define TTC_GATE1     7
`define TTC_CT1       6
`define TTC_M1_HI     5
`define TTC_M1_LO     4
`define TTC_GATE_SELECT_T0     3
`define TTC_CT0       2
`define TTC_M0_HI     1
`define TTC_M0_LO     0
// timer2_control fields
`define TTC_TF2       7
`define TTC_EXTERNAL_EVENT_FLAG      6
`define TTC_RCLK      5
`define TTC_TX_BAUD_SOURCE      4
`define TTC_EXTERNAL_EVENT_ENABLE     3
`define TTC_TR2       2
`define TTC_CT2       1
`define TTC_CAPTURE_SELECT      0
// pin synchroniser
`define TTC_NPIN      6
`endif

// file: core/ttc_pkg.sv
// Purpose: types of the three timer/counter unit
// Assumes: apb3 signalling, 32-bit data
// Notes:   pin struct order is the synchroniser bit order
package ttc_pkg;
    typedef enum logic [1:0] {
        TTC_M13 = 2'h0, TTC_M16 = 2'h1, TTC_M8R = 2'h2, TTC_MSPLIT = 2'h3
    } ttc_mode_t;
    typedef enum logic [3:0] {
        TTC_T2_OFF = 4'h1, TTC_T2_AUTO = 4'h2, TTC_T2_CAPT = 4'h4, TTC_T2_BAUD = 4'h8
    } ttc_t2mode_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [9:0]  paddr;
        logic [31:0] pwdata;
    } ttc_apb_t;
    typedef struct packed {
        logic trigger_pin;
        logic count_pin_third;
        logic count_pin_one;
        logic count_pin_zero;
        logic ext_irq_pin_one;
        logic ext_irq_pin_zero;
    } ttc_pins_t;
endpackage

// file: core/ttc_top.sv
// Purpose: three timer/counters behind an apb slave
// Assumes: pins asynchronous to pclk, 40 MHz pclk
// Notes:   registers are byte wide in the low lane of each word
//
// Contract
// - two byte registers per timer 0/1
// - timers count every core clock, or pin falls in counter mode, no prescaler
// - mode 0 is 13 bits, low five bits
// - wrap from all ones sets overflow flag
// - count only if run and (no gate or pin)
// - setting run never clears the counts
// - mode 1 is mode 0 with sixteen bits
// - mode 2 reloads low from high byte
// - timer 1 in mode 3 holds its count
// - timer 0 mode 3 splits into two bytes
// - timer 1 then runs but sets no flag
// - timer 2 mode decoded from run, baud, capture
// - timer 2 autoreload on rollover sets flag
// - trigger fall reloads and sets external flag
// - capture mode counts sixteen bits, no reload
// - trigger fall captures count, sets external flag
// - baud mode never sets timer 2 overflow
// - timer 2 counts pin edges or clocks
// - timer 2 flag sticky until software clears
// - baud bits pick timer 2 or timer 1
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "ttc_defines.svh"
module ttc_top (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire ttc_pkg::ttc_apb_t apb_in,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // external pins
    input  wire ttc_pkg::ttc_pins_t pins,
    // flags and serial port clocks
    output logic                   overflow_flag_t0,
    output logic                   overflow_flag_t1,
    output logic                   overflow_flag_third,
    output logic                   external_event_flag,
    output logic                   rx_baud_tick,
    output logic                   tx_baud_tick
);
    import ttc_pkg::*;

    logic [7:0] tcf_q, tms_q, t2c_q, tl0_q, th0_q, tl1_q, th1_q;
    logic [7:0] tl2_q, th2_q, rcl_q, rch_q;
    logic [7:0] tcf_d, t2c_d, tl0_d, th0_d, tl1_d, th1_d;
    logic [7:0] tl2_d, th2_d, rcl_d, rch_d;
    logic [31:0] prdata_q;
    logic       rxb_q, txb_q;

    // apb decode
    wire        setup   = apb_in.psel & ~apb_in.penable;
    wire        access  = apb_in.psel & apb_in.penable;
    wire [7:0]  idx     = apb_in.paddr[9:2];
    wire [7:0]  wd      = apb_in.pwdata[7:0];
    wire        hit     = (idx == `TTC_IDX_TCF) || (idx == `TTC_IDX_TMS) ||
                          (idx == `TTC_IDX_TL0) || (idx == `TTC_IDX_TL1) ||
                          (idx == `TTC_IDX_TH0) || (idx == `TTC_IDX_TH1) ||
                          (idx == `TTC_IDX_T2C) || (idx == `TTC_IDX_RCL) ||
                          (idx == `TTC_IDX_RCH) || (idx == `TTC_IDX_TL2) ||
                          (idx == `TTC_IDX_TH2);
    wire        wen     = access & apb_in.pwrite & hit;
    wire        w_tcf   = wen && idx == `TTC_IDX_TCF;
    wire        w_tms   = wen && idx == `TTC_IDX_TMS;
    wire        w_tl0   = wen && idx == `TTC_IDX_TL0;
    wire        w_tl1   = wen && idx == `TTC_IDX_TL1;
    wire        w_th0   = wen && idx == `TTC_IDX_TH0;
    wire        w_th1   = wen && idx == `TTC_IDX_TH1;
    wire        w_t2c   = wen && idx == `TTC_IDX_T2C;
    wire        w_rcl   = wen && idx == `TTC_IDX_RCL;
    wire        w_rch   = wen && idx == `TTC_IDX_RCH;
    wire        w_tl2   = wen && idx == `TTC_IDX_TL2;
    wire        w_th2   = wen && idx == `TTC_IDX_TH2;

    // read mux, sampled in the setup cycle
    wire [7:0]  rsel = (idx == `TTC_IDX_TCF) ? tcf_q :
                       (idx == `TTC_IDX_TMS) ? tms_q :
                       (idx == `TTC_IDX_TL0) ? tl0_q :
                       (idx == `TTC_IDX_TL1) ? tl1_q :
                       (idx == `TTC_IDX_TH0) ? th0_q :
                       (idx == `TTC_IDX_TH1) ? th1_q :
                       (idx == `TTC_IDX_T2C) ? t2c_q :
                       (idx == `TTC_IDX_RCL) ? rcl_q :
                       (idx == `TTC_IDX_RCH) ? rch_q :
                       (idx == `TTC_IDX_TL2) ? tl2_q :
                       (idx == `TTC_IDX_TH2) ? th2_q : `TTC_RST8;
    wire [31:0] rword = {24'h000000, rsel};
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata  = prdata_q;

    // pin synchroniser: three flops, change taken when 2nd and 3rd agree
    logic [`TTC_NPIN-1:0] s1_q, s2_q, s3_q, st_q, pv_q;
    wire  [`TTC_NPIN-1:0] pin_v = pins;
    for (genvar i = 0; i < `TTC_NPIN; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
                s3_q[i] <= 1'b0;
                st_q[i] <= 1'b0;
                pv_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= pin_v[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                st_q[i] <= (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
                pv_q[i] <= st_q[i];
            end
        end
    end
    // falling edges from consecutive filtered samples
    ttc_pins_t lvl, fall;
    assign lvl  = st_q;
    assign fall = pv_q & ~st_q;

    // timer 0/1 control decode
    ttc_mode_t m0, m1;
    assign m0 = ttc_mode_t'(tms_q[`TTC_M0_HI:`TTC_M0_LO]);
    assign m1 = ttc_mode_t'(tms_q[`TTC_M1_HI:`TTC_M1_LO]);
    wire src0 = tms_q[`TTC_CT0] ? fall.count_pin_zero : 1'b1;
    wire src1 = tms_q[`TTC_CT1] ? fall.count_pin_one : 1'b1;
    wire en0  = tcf_q[`TTC_TR0] & (~tms_q[`TTC_GATE_SELECT_T0] | lvl.ext_irq_pin_zero) & src0;
    wire en1  = tcf_q[`TTC_TR1] & (~tms_q[`TTC_GATE1] | lvl.ext_irq_pin_one) & src1
                & (m1 != TTC_MSPLIT);
    wire split = (m0 == TTC_MSPLIT);

    // one count step of a timer 0/1: {overflow, high, low}
    function automatic logic [16:0] step(input ttc_mode_t m, input logic [7:0] tl,
                                         input logic [7:0] th, input logic en);
        logic [12:0] v13;
        logic [15:0] v16;
        logic        o;
        logic [15:0] c;
        v13 = {th, tl[4:0]} + 13'd1;
        v16 = {th, tl} + 16'd1;
        o   = 1'b0;
        c   = {th, tl};
        if (en) begin
            unique case (m)
                TTC_M13: begin
                    o = &{th, tl[4:0]};
                    c = {v13[12:5], tl[7:5], v13[4:0]};
                end
                TTC_M16: begin
                    o = &{th, tl};
                    c = v16;
                end
                TTC_M8R: begin
                    o = &tl;
                    c = {th, (o ? th : v16[7:0])};
                end
                TTC_MSPLIT: begin
                    o = &tl;
                    c = {th, v16[7:0]};
                end
            endcase
        end
        return {o, c};
    endfunction

    wire [16:0] r0 = step(m0, tl0_q, th0_q, en0);
    wire [16:0] r1 = step(m1, tl1_q, th1_q, en1);
    wire        ovf0 = r0[16];
    wire        ovf1 = r1[16];
    // split high byte counts core clocks under the second run bit
    wire        en0h  = split & tcf_q[`TTC_TR1];
    wire        ovf0h = en0h & (&th0_q);
    wire [7:0]  th0_inc = th0_q + 8'd1;
    // second timer flag source depends on the split
    wire        set_tf1 = split ? ovf0h : ovf1;

    // timer 0/1 next values; a software write wins over counting
    assign tl0_d = w_tl0 ? wd : r0[7:0];
    assign th0_d = w_th0 ? wd : (en0h ? th0_inc : r0[15:8]);
    assign tl1_d = w_tl1 ? wd : r1[7:0];
    assign th1_d = w_th1 ? wd : r1[15:8];

    // control flags: hardware set wins over a software clear
    always_comb begin
        tcf_d = w_tcf ? wd : tcf_q;
        if (ovf0) begin
            tcf_d[`TTC_TF0] = 1'b1;
        end
        if (set_tf1) begin
            tcf_d[`TTC_TF1] = 1'b1;
        end
    end

    // timer 2 mode decode
    ttc_t2mode_t m2;
    wire baud_sel = t2c_q[`TTC_RCLK] | t2c_q[`TTC_TX_BAUD_SOURCE];
    assign m2 = !t2c_q[`TTC_TR2] ? TTC_T2_OFF :
                baud_sel          ? TTC_T2_BAUD :
                t2c_q[`TTC_CAPTURE_SELECT]  ? TTC_T2_CAPT : TTC_T2_AUTO;
    wire        en2   = (m2 != TTC_T2_OFF) &
                        (t2c_q[`TTC_CT2] ? fall.count_pin_third : 1'b1);
    wire [15:0] cnt2  = {th2_q, tl2_q};
    wire [15:0] inc2  = cnt2 + 16'd1;
    wire        ovf2  = en2 & (&cnt2);
    wire        xev   = t2c_q[`TTC_EXTERNAL_EVENT_ENABLE] & fall.trigger_pin;
    wire        xrld  = xev & (m2 == TTC_T2_AUTO);
    wire        xcap  = xev & (m2 == TTC_T2_CAPT);
    wire        rld2  = xrld | (ovf2 & (m2 != TTC_T2_CAPT));
    wire [15:0] nxt2  = rld2 ? {rch_q, rcl_q} : (en2 ? inc2 : cnt2);

    assign tl2_d = w_tl2 ? wd : nxt2[7:0];
    assign th2_d = w_th2 ? wd : nxt2[15:8];
    // capture wins over a software write of the same byte
    assign rcl_d = xcap ? tl2_q : (w_rcl ? wd : rcl_q);
    assign rch_d = xcap ? th2_q : (w_rch ? wd : rch_q);

    always_comb begin
        t2c_d = w_t2c ? wd : t2c_q;
        if (ovf2 && m2 != TTC_T2_BAUD) begin
            t2c_d[`TTC_TF2] = 1'b1;
        end
        if (xev && (m2 == TTC_T2_AUTO || m2 == TTC_T2_CAPT || m2 == TTC_T2_BAUD)) begin
            t2c_d[`TTC_EXTERNAL_EVENT_FLAG] = 1'b1;
        end
    end

    // serial clock routing
    wire rx_src = t2c_q[`TTC_RCLK] ? ovf2 : ovf1;
    wire tx_src = t2c_q[`TTC_TX_BAUD_SOURCE] ? ovf2 : ovf1;

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcf_q <= `TTC_RST8;
            tms_q <= `TTC_RST8;
            t2c_q <= `TTC_RST8;
            tl0_q <= `TTC_RST8;
            th0_q <= `TTC_RST8;
            tl1_q <= `TTC_RST8;
            th1_q <= `TTC_RST8;
            tl2_q <= `TTC_RST8;
            th2_q <= `TTC_RST8;
            rcl_q <= `TTC_RST8;
            rch_q <= `TTC_RST8;
        end else begin
            tcf_q <= tcf_d;
            tms_q <= w_tms ? wd : tms_q;
            t2c_q <= t2c_d;
            tl0_q <= tl0_d;
            th0_q <= th0_d;
            tl1_q <= tl1_d;
            th1_q <= th1_d;
            tl2_q <= tl2_d;
            th2_q <= th2_d;
            rcl_q <= rcl_d;
            rch_q <= rch_d;
        end
    end

    // read data and serial ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            rxb_q    <= 1'b0;
            txb_q    <= 1'b0;
        end else begin
            prdata_q <= setup ? rword : prdata_q;
            rxb_q    <= rx_src;
            txb_q    <= tx_src;
        end
    end

    assign overflow_flag_t0    = tcf_q[`TTC_TF0];
    assign overflow_flag_t1    = tcf_q[`TTC_TF1];
    assign overflow_flag_third = t2c_q[`TTC_TF2];
    assign external_event_flag = t2c_q[`TTC_EXTERNAL_EVENT_FLAG];
    assign rx_baud_tick        = rxb_q;
    assign tx_baud_tick        = txb_q;

    // checks
    property p_inc16;
        @(posedge pclk) disable iff (!presetn)
        (m0 == TTC_M16 && tcf_q[`TTC_TR0] && !tms_q[`TTC_GATE_SELECT_T0] && !tms_q[`TTC_CT0]
         && !w_tl0 && !w_th0)
        |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'd1;
    endproperty
    a_inc16: assert property (p_inc16) else $error("timer 0 missed a clock");

    property p_ovf0;
        @(posedge pclk) disable iff (!presetn)
        (m0 == TTC_M16 && en0 && &{th0_q, tl0_q} && !w_tl0 && !w_th0)
        |=> tcf_q[`TTC_TF0] && {th0_q, tl0_q} == 16'h0000;
    endproperty
    a_ovf0: assert property (p_ovf0) else $error("timer 0 wrap lost");

    property p_m0top;
        @(posedge pclk) disable iff (!presetn)
        (m0 == TTC_M13 && !w_tl0) |=> tl0_q[7:5] == $past(tl0_q[7:5]);
    endproperty
    a_m0top: assert property (p_m0top) else $error("mode 0 touched top bits");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        (!tcf_q[`TTC_TR0] && !w_tl0 && !w_th0)
        |=> tl0_q == $past(tl0_q) && (th0_q == $past(th0_q) || $past(en0h));
    endproperty
    a_gate: assert property (p_gate) else $error("timer 0 ran while stopped");

    property p_rld8;
        @(posedge pclk) disable iff (!presetn)
        (m0 == TTC_M8R && en0 && &tl0_q && !w_tl0 && !w_th0)
        |=> tl0_q == $past(th0_q) && tcf_q[`TTC_TF0];
    endproperty
    a_rld8: assert property (p_rld8) else $error("mode 2 reload wrong");

    property p_hold1;
        @(posedge pclk) disable iff (!presetn)
        (m1 == TTC_MSPLIT && !w_tl1 && !w_th1) [*2] |=> $stable({th1_q, tl1_q});
    endproperty
    a_hold1: assert property (p_hold1) else $error("timer 1 moved in mode 3");

    property p_rld16;
        @(posedge pclk) disable iff (!presetn)
        (m2 == TTC_T2_AUTO && ovf2 && !w_tl2 && !w_th2)
        |=> {th2_q, tl2_q} == $past({rch_q, rcl_q}) && t2c_q[`TTC_TF2];
    endproperty
    a_rld16: assert property (p_rld16) else $error("timer 2 reload wrong");

    property p_cap;
        @(posedge pclk) disable iff (!presetn)
        xcap |=> {rch_q, rcl_q} == $past(cnt2) && t2c_q[`TTC_EXTERNAL_EVENT_FLAG];
    endproperty
    a_cap: assert property (p_cap) else $error("capture wrong");

    property p_baud;
        @(posedge pclk) disable iff (!presetn)
        (m2 == TTC_T2_BAUD && !t2c_q[`TTC_TF2] && !w_t2c) |=> !t2c_q[`TTC_TF2];
    endproperty
    a_baud: assert property (p_baud) else $error("overflow flag set in baud mode");

    property p_splithi;
        @(posedge pclk) disable iff (!presetn)
        (split && tcf_q[`TTC_TR1] && !w_th0) |=> th0_q == $past(th0_q) + 8'd1;
    endproperty
    a_splithi: assert property (p_splithi) else $error("split high byte stalled");

    property p_tf1own;
        @(posedge pclk) disable iff (!presetn)
        (split && !ovf0h && !tcf_q[`TTC_TF1] && !w_tcf) |=> !tcf_q[`TTC_TF1];
    endproperty
    a_tf1own: assert property (p_tf1own) else $error("timer 1 set its own flag");

    property p_cap16;
        @(posedge pclk) disable iff (!presetn)
        (m2 == TTC_T2_CAPT && ovf2 && !w_tl2 && !w_th2)
        |=> {th2_q, tl2_q} == 16'h0000 && t2c_q[`TTC_TF2];
    endproperty
    a_cap16: assert property (p_cap16) else $error("capture mode reloaded");

    property p_xrld;
        @(posedge pclk) disable iff (!presetn)
        (xrld && !w_tl2 && !w_th2)
        |=> {th2_q, tl2_q} == $past({rch_q, rcl_q}) && t2c_q[`TTC_EXTERNAL_EVENT_FLAG];
    endproperty
    a_xrld: assert property (p_xrld) else $error("trigger reload wrong");

    property p_tf2hold;
        @(posedge pclk) disable iff (!presetn)
        (t2c_q[`TTC_TF2] && !w_t2c) |=> t2c_q[`TTC_TF2];
    endproperty
    a_tf2hold: assert property (p_tf2hold) else $error("timer 2 flag dropped");

    property p_txtick;
        @(posedge pclk) disable iff (!presetn)
        (t2c_q[`TTC_TX_BAUD_SOURCE] && ovf2) |=> tx_baud_tick;
    endproperty
    a_txtick: assert property (p_txtick) else $error("transmit tick missing");
endmodule

// file: tb/ttc_pin_model.sv
// Purpose: far-side pin driver for the timer unit
// Assumes: bench asks for pin levels, model applies them
// Notes:   levels move only just after a rising edge
`timescale 1ns/1ps
module ttc_pin_model (
    // clock
    input  wire logic               pclk,
    // levels asked for by the bench
    input  wire ttc_pkg::ttc_pins_t want,
    // levels on the pins
    output ttc_pkg::ttc_pins_t      pins
);
    import ttc_pkg::*;
    // idle pins sit high, as with pull-ups
    initial pins = '1;
    // pins follow the request one edge later
    always @(posedge pclk) begin
        pins <= want;
    end
endmodule

// file: tb/test_three_timer_counter_unit.sv
// Purpose: self-checking bench of the three timer/counter unit
// Assumes: apb slave answers in the access cycle
// Notes:   counts are read back after the timer has been stopped, except in the timer 2 pin count test
`timescale 1ns/1ps
`include "ttc_defines.svh"
module test_three_timer_counter_unit;
    import ttc_pkg::*;
    // clock, reset, bus and pins
    logic        pclk;
    logic        presetn;
    ttc_apb_t    apb;
    ttc_pins_t   want;
    ttc_pins_t   pins;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        of0, of1, of2, exf, rxt, txt;
    int          error_cnt = 0;
    int          check_count = 0;
    int          rx_n, tx_n, k;
    logic [7:0]  rv;
    logic        er;
    logic [16:0] e;
    logic [15:0] c, r;
    logic [7:0]  regs [11] = '{`TTC_IDX_TCF, `TTC_IDX_TMS, `TTC_IDX_TL0, `TTC_IDX_TL1,
        `TTC_IDX_TH0, `TTC_IDX_TH1, `TTC_IDX_T2C, `TTC_IDX_RCL, `TTC_IDX_RCH,
        `TTC_IDX_TL2, `TTC_IDX_TH2};
    logic [7:0]  t2c [4] = '{8'h04, 8'h05, 8'h14, 8'h24};

    ttc_top dut_u (.pclk(pclk), .presetn(presetn), .apb_in(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .overflow_flag_t0(of0),
        .overflow_flag_t1(of1), .overflow_flag_third(of2), .external_event_flag(exf),
        .rx_baud_tick(rxt), .tx_baud_tick(txt));
    ttc_pin_model pin_u (.pclk(pclk), .want(want), .pins(pins));

    // clock
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;
    // serial clock pulses seen
    always @(posedge pclk) begin
        if (rxt === 1'b1) rx_n++;
        if (txt === 1'b1) tx_n++;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, entered just after an edge, idles one cycle after
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= wr;
        apb.paddr <= {idx, 2'b00};
        apb.pwdata <= {24'h0, wd};
        @(posedge pclk);
        apb.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40) begin
            error_cnt++;
            stop_test();
        end
        rd = prdata[7:0];
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        logic       y;
        xfer(1'b1, idx, d, x, y);
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        logic       y;
        xfer(1'b0, idx, 8'h00, x, y);
        chk(nm, {8'h00, exp}, {8'h00, x});
    endtask

    // count after n steps: 0 13-bit, 1 16-bit, 2 byte reload, 4 reload, 5 none
    function automatic logic [16:0] cnt_exp(input int md, input logic [15:0] c0,
                                            input logic [15:0] rl, input int n);
        logic [15:0] v;
        logic [12:0] w;
        logic        f;
        v = c0;
        f = 1'b0;
        repeat (n) begin
            w = {v[15:8], v[4:0]} + 13'h1;
            case (md)
                0: begin
                    v = {w[12:5], v[7:5], w[4:0]};
                    if (w == 13'h0) f = 1'b1;
                end
                2: begin
                    v[7:0] = v[7:0] + 8'h1;
                    if (v[7:0] == 8'h0) begin
                        v[7:0] = v[15:8];
                        f = 1'b1;
                    end
                end
                default: begin
                    v = v + 16'h1;
                    if (v == 16'h0) begin
                        f = 1'b1;
                        if (md == 4) v = rl;
                    end
                end
            endcase
        end
        return {f, v};
    endfunction

    initial begin
        presetn = 1'b0;
        apb = '0;
        want = '1;
        rx_n = 0;
        tx_n = 0;
        void'($urandom(7));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // register defaults and an unmapped place
        foreach (regs[i]) begin
            xfer(1'b0, regs[i], 8'h00, rv, er);
            chk("reset value", {8'h00, `TTC_RST8}, {8'h00, rv});
        end
        xfer(1'b0, 8'h90, 8'h00, rv, er);
        chk("unmapped error", 16'h1, {15'h0, er});
        $display("test reset values done");
        // timers 0 and 1 in modes 0, 1 and 2
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                c = 16'hFFE0 | 16'($urandom_range(0, 31));
                if (m == 2) c[15:8] = 8'($urandom);
                k = $urandom_range(36, 50);
                wr(`TTC_IDX_TMS, t ? 8'(m << 4) : 8'(m));
                wr(t ? `TTC_IDX_TL1 : `TTC_IDX_TL0, c[7:0]);
                wr(t ? `TTC_IDX_TH1 : `TTC_IDX_TH0, c[15:8]);
                wr(`TTC_IDX_TCF, t ? 8'h40 : 8'h10);
                repeat (k) @(posedge pclk);
                e = cnt_exp(m, c, 16'h0, k);
                chk("overflow flag", {15'h0, e[16]}, {15'h0, t ? of1 : of0});
                wr(`TTC_IDX_TCF, 8'h00);
                e = cnt_exp(m, c, 16'h0, k + 3);
                rdc("count low", t ? `TTC_IDX_TL1 : `TTC_IDX_TL0, e[7:0]);
                rdc("count high", t ? `TTC_IDX_TH1 : `TTC_IDX_TH0, e[15:8]);
            end
        end
        $display("test timer modes done");
        // gate held low keeps timer 0 still
        want.ext_irq_pin_zero <= 1'b0;
        wr(`TTC_IDX_TMS, 8'h09);
        wr(`TTC_IDX_TL0, 8'h00);
        wr(`TTC_IDX_TH0, 8'h00);
        wr(`TTC_IDX_TCF, 8'h10);
        repeat (10) @(posedge pclk);
        wr(`TTC_IDX_TCF, 8'h00);
        rdc("gated count", `TTC_IDX_TL0, 8'h00);
        want.ext_irq_pin_zero <= 1'b1;
        // timer 0 split, timer 1 holding
        wr(`TTC_IDX_TMS, 8'h33);
        wr(`TTC_IDX_TL0, 8'h10);
        wr(`TTC_IDX_TH0, 8'hF8);
        wr(`TTC_IDX_TL1, 8'h55);
        wr(`TTC_IDX_TCF, 8'h50);
        repeat (12) @(posedge pclk);
        chk("split high flag", 16'h1, {15'h0, of1});
        chk("split low flag", 16'h0, {15'h0, of0});
        wr(`TTC_IDX_TCF, 8'h00);
        rdc("split low", `TTC_IDX_TL0, 8'h1F);
        rdc("split high", `TTC_IDX_TH0, 8'h07);
        rdc("held timer 1", `TTC_IDX_TL1, 8'h55);
        $display("test gate and split done");
        // timer 2 reload, capture and both baud selections
        foreach (t2c[j]) begin
            c = 16'hFFE0 | 16'($urandom_range(0, 31));
            r = 16'($urandom_range(0, 16'hFF00));
            k = $urandom_range(36, 50);
            wr(`TTC_IDX_RCL, r[7:0]);
            wr(`TTC_IDX_RCH, r[15:8]);
            wr(`TTC_IDX_TL2, c[7:0]);
            wr(`TTC_IDX_TH2, c[15:8]);
            rx_n = 0;
            tx_n = 0;
            wr(`TTC_IDX_T2C, t2c[j]);
            repeat (k) @(posedge pclk);
            e = cnt_exp(t2c[j] == 8'h05 ? 5 : 4, c, r, k);
            er = e[16] & (t2c[j][5:4] == 2'b00);
            chk("timer2 flag", {15'h0, er}, {15'h0, of2});
            wr(`TTC_IDX_T2C, 8'h00);
            e = cnt_exp(t2c[j] == 8'h05 ? 5 : 4, c, r, k + 3);
            rdc("timer2 low", `TTC_IDX_TL2, e[7:0]);
            rdc("timer2 high", `TTC_IDX_TH2, e[15:8]);
            chk("tx ticks", {15'h0, t2c[j] == 8'h14}, 16'(tx_n));
            chk("rx ticks", {15'h0, t2c[j] == 8'h24}, 16'(rx_n));
        end
        // trigger fall captures the running count
        wr(`TTC_IDX_TL2, 8'h00);
        wr(`TTC_IDX_TH2, 8'h00);
        wr(`TTC_IDX_T2C, 8'h0D);
        want.trigger_pin <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("external flag", 16'h1, {15'h0, exf});
        wr(`TTC_IDX_T2C, 8'h00);
        xfer(1'b0, `TTC_IDX_RCL, 8'h00, rv, er);
        chk("capture low", 16'h1, {15'h0, rv >= 8'h01 && rv <= 8'h17});
        rdc("capture high", `TTC_IDX_RCH, 8'h00);
        want.trigger_pin <= 1'b1;
        // count pin edges in autoreload, then a trigger fall reloads
        r = 16'($urandom);
        k = $urandom_range(2, 9);
        wr(`TTC_IDX_RCL, r[7:0]);
        wr(`TTC_IDX_RCH, r[15:8]);
        wr(`TTC_IDX_TL2, 8'h00);
        wr(`TTC_IDX_TH2, 8'h00);
        wr(`TTC_IDX_T2C, 8'h0E);
        repeat (k) begin
            want.count_pin_third <= 1'b0;
            repeat (6) @(posedge pclk);
            want.count_pin_third <= 1'b1;
            repeat (6) @(posedge pclk);
        end
        rdc("pin count", `TTC_IDX_TL2, 8'(k));
        want.trigger_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        chk("reload flag", 16'h1, {15'h0, exf});
        rdc("reload low", `TTC_IDX_TL2, r[7:0]);
        rdc("reload high", `TTC_IDX_TH2, r[15:8]);
        want.trigger_pin <= 1'b1;
        wr(`TTC_IDX_T2C, 8'h00);
        $display("test timer 2 done");
        stop_test();
    end
endmodule
